// [ast_pkg.sv]
// Constants, register map and state types of the asynchronous serial transceiver
package ast_pkg;

  // Register indices on the plain register port
  localparam logic [2:0] ADDR_MODE = 3'h0;
  localparam logic [2:0] ADDR_STATUS = 3'h1;
  localparam logic [2:0] ADDR_BAUD = 3'h2;
  localparam logic [2:0] ADDR_TXS = 3'h3;
  localparam logic [2:0] ADDR_RXB = 3'h4;

  // Field positions in the line mode register
  localparam int MODE_POWER = 7;
  localparam int MODE_TXE = 6;
  localparam int MODE_RXE = 5;
  localparam int MODE_PS_HI = 4;
  localparam int MODE_PS_LO = 3;
  localparam int MODE_CL = 2;
  localparam int MODE_SL = 1;
  localparam int MODE_FIXED = 0;

  // Field positions in the receive error status register
  localparam int STAT_PE = 2;
  localparam int STAT_FE = 1;
  localparam int STAT_OVE = 0;

  // Field positions in the baud generator control register
  localparam int BAUD_TPS_HI = 7;
  localparam int BAUD_TPS_LO = 6;
  localparam int BAUD_MDL_HI = 4;
  localparam int BAUD_MDL_LO = 0;

  // Reset values
  localparam logic [7:0] MODE_RST = 8'h01;
  localparam logic [7:0] BAUD_RST = 8'h1f;
  localparam logic [7:0] RXB_RST = 8'hff;
  localparam logic [7:0] TXS_RST = 8'hff;
  localparam logic [2:0] STAT_RST = 3'h0;

  // Parity selections
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ZERO = 2'h1;
  localparam logic [1:0] PAR_ODD = 2'h2;
  localparam logic [1:0] PAR_EVEN = 2'h3;

  // Base clock selections and prescaler masks
  localparam logic [1:0] TPS_TIMER = 2'h0;
  localparam logic [1:0] TPS_DIV2 = 2'h1;
  localparam logic [1:0] TPS_DIV8 = 2'h2;
  localparam logic [4:0] PRE_MASK_DIV2 = 5'h01;
  localparam logic [4:0] PRE_MASK_DIV8 = 5'h07;
  localparam logic [4:0] PRE_MASK_DIV32 = 5'h1f;

  // Character lengths minus one
  localparam logic [2:0] LAST_BIT_7 = 3'h6;
  localparam logic [2:0] LAST_BIT_8 = 3'h7;

  typedef enum logic [2:0] {
    TX_IDLE = 3'h0,
    TX_START = 3'h1,
    TX_DATA = 3'h2,
    TX_PAR = 3'h3,
    TX_STOP1 = 3'h4,
    TX_STOP2 = 3'h5
  } ast_tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE = 3'h0,
    RX_START = 3'h1,
    RX_DATA = 3'h2,
    RX_PAR = 3'h3,
    RX_STOP = 3'h4
  } ast_rx_state_t;

endpackage

// [ast_baud_counter.sv]
// Programmable base-clock tick counter giving one hit per period
`timescale 1ns/1ps
module ast_baud_counter (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // Control
  input wire logic i_clear,
  input wire logic i_tick,
  input wire logic [5:0] i_limit,
  // Period hit
  output logic o_hit
);
  logic [5:0] cnt_ff;
  logic [5:0] nxt_cnt;

  // Hit on the last base tick of the period
  assign o_hit = i_tick && !i_clear && (cnt_ff == (i_limit - 6'h01));

  // Next count: clear, wrap on hit, or step on tick
  always_comb begin
    nxt_cnt = cnt_ff;
    if (i_clear) begin
      nxt_cnt = 6'h00;
    end else if (o_hit) begin
      nxt_cnt = 6'h00;
    end else if (i_tick) begin
      nxt_cnt = cnt_ff + 6'h01;
    end
  end

  // Counter register
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_ff <= 6'h00;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end
endmodule

// [ast_noise_filter.sv]
// Synchroniser and two-sample agreement filter for the serial input
`timescale 1ns/1ps
module ast_noise_filter (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // Sampling control
  input wire logic i_tick,
  input wire logic i_force_high,
  // Line
  input wire logic i_serial,
  output logic o_level
);
  logic sync1_ff;
  logic sync2_ff;
  logic samp_a_ff;
  logic samp_b_ff;
  logic level_ff;
  logic line_in;

  // Two-flop synchroniser, idle high
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sync1_ff <= 1'b1;
      sync2_ff <= 1'b1;
    end else begin
      sync1_ff <= i_serial;
      sync2_ff <= sync1_ff;
    end
  end

  // Input held high while the unit is unpowered
  assign line_in = i_force_high | sync2_ff;

  // Accept a new level only when two base-clock samples agree
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      samp_a_ff <= 1'b1;
      samp_b_ff <= 1'b1;
      level_ff <= 1'b1;
    end else if (i_tick) begin
      samp_a_ff <= line_in;
      samp_b_ff <= samp_a_ff;
      if (samp_a_ff == samp_b_ff) begin
        level_ff <= samp_b_ff; // RULE23
      end
    end
  end

  assign o_level = level_ff;
endmodule

// [ast_top.sv]
// Full-duplex asynchronous serial transceiver with register port
// Behaviour
// [RULE1] All three enables clear: stop the unit and release both line pins.
// [RULE2] Frame is start, 7 or 8 bits LSB first, optional parity, 1-2 stops.
// [RULE3] Even parity: ones count including parity even; odd count flags error.
// [RULE4] Odd parity: ones count including parity odd; even count flags error.
// [RULE5] Zero parity: send 0, receiver skips bit, no parity error.
// [RULE6] No parity: no bit sent, receiver expects none, no parity error.
// [RULE7] Powered and transmit enabled, writing the transmit register starts a frame.
// [RULE8] Start bit goes out first, then character bits from the LSB.
// [RULE9] Transmit-done pulses when the final stop bit has been output.
// [RULE10] After a frame the transmitter idles until the next character write.
// [RULE11] Software waits for transmit-done before writing the next character.
// [RULE12] Receiver samples the input only when powered and receive enabled.
// [RULE13] Falling edge starts the counter; low after k ticks confirms start.
// [RULE14] Bits shift in at baud rate; stop gives interrupt and buffer copy unless overrun.
// [RULE15] Parity error does not abort; interrupt comes after the stop position.
// [RULE16] Receiver checks exactly one stop bit, ignoring a second one.
// [RULE17] Any error flag set by a frame raises the same receive interrupt.
// [RULE18] Reading the error status register clears all its flags.
// [RULE19] Framing error is set when the stop bit position is not high.
// [RULE20] Overrun is set when a frame completes before the buffer was read.
// [RULE21] After an error software reads status then buffer, else overrun follows.
// [RULE22] Power off resets status, transmit and receive registers; clock held low.
// [RULE23] Input filter accepts a level when two base-clock samples agree.
// [RULE24] Bit rate is the divider output divided by two.
// [RULE25] Seven-bit characters: parity over seven bits, received data in low bits.
//
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
module ast_top (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // Register port
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  output logic [7:0] o_rd_data,
  // Alternative base clock source
  input wire logic i_timer_tick,
  // Serial line
  output logic o_serial_tx_pin,
  output logic o_serial_tx_pin_oe,
  input wire logic i_serial_rx_pin,
  output logic o_serial_rx_pin_sel,
  // Events
  output logic o_tx_done_interrupt,
  output logic o_rx_done_interrupt
);
  import ast_pkg::*;

  logic [7:0] mode_ff;
  logic [7:0] baud_ff;
  logic [7:0] txs_ff;
  logic [7:0] rxb_ff;
  logic [7:0] rxs_ff;
  logic [7:0] tx_sh_ff;
  logic [7:0] rd_data_ff;
  logic [2:0] status_ff;
  logic [2:0] nxt_status;
  logic [4:0] pre_ff;
  logic [4:0] pre_mask;
  logic [2:0] tx_bit_ff;
  logic [2:0] rx_bit_ff;
  logic [2:0] last_bit;
  logic [5:0] tx_limit;
  logic [5:0] rx_limit;
  logic [1:0] parity_mode;
  ast_tx_state_t tx_state_ff;
  ast_rx_state_t rx_state_ff;
  logic unit_power;
  logic unit_rst_b;
  logic tx_en;
  logic rx_en;
  logic base_tick;
  logic tx_hit;
  logic rx_hit;
  logic tx_start;
  logic tx_out_ff;
  logic tx_done_ff;
  logic rx_done_ff;
  logic rx_level;
  logic rx_prev_ff;
  logic rx_fall;
  logic rx_par_ff;
  logic rxb_full_ff;
  logic rx_clear;
  logic frame_end;
  logic set_pe;
  logic set_fe;
  logic set_ove;
  logic rd_status;
  logic rd_rxb;

  // Decoded enables
  assign unit_power = mode_ff[MODE_POWER];
  assign tx_en = unit_power & mode_ff[MODE_TXE];
  assign rx_en = unit_power & mode_ff[MODE_RXE]; // RULE12
  assign parity_mode = mode_ff[MODE_PS_HI:MODE_PS_LO];
  assign last_bit = mode_ff[MODE_CL] ? LAST_BIT_8 : LAST_BIT_7; // RULE2
  assign unit_rst_b = i_rst_b & unit_power; // RULE22

  // Pin ownership follows the enables
  assign o_serial_tx_pin_oe = tx_en; // RULE1
  assign o_serial_rx_pin_sel = rx_en; // RULE1
  assign o_serial_tx_pin = tx_out_ff;
  assign o_tx_done_interrupt = tx_done_ff;
  assign o_rx_done_interrupt = rx_done_ff;
  assign o_rd_data = rd_data_ff;

  // Register port decodes
  assign tx_start = i_wr_en && (i_addr == ADDR_TXS) && tx_en && (tx_state_ff == TX_IDLE);
  assign rd_status = i_rd_en && (i_addr == ADDR_STATUS);
  assign rd_rxb = i_rd_en && (i_addr == ADDR_RXB);

  // Mode register, lowest bit fixed at one
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mode_ff <= MODE_RST;
    end else if (i_wr_en && (i_addr == ADDR_MODE)) begin
      mode_ff <= {i_wr_data[7:1], 1'b1};
    end
  end

  // Baud generator control register
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      baud_ff <= BAUD_RST;
    end else if (i_wr_en && (i_addr == ADDR_BAUD)) begin
      baud_ff <= i_wr_data;
    end
  end

  // Transmit holding register, reset to all ones with the power bit
  always_ff @(posedge i_core_clk or negedge unit_rst_b) begin
    if (!unit_rst_b) begin
      txs_ff <= TXS_RST; // RULE22
    end else if (tx_start) begin
      txs_ff <= i_wr_data;
    end
  end

  // Read data, valid in the cycle after the strobe
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rd_data_ff <= 8'h00;
    end else if (i_rd_en) begin
      case (i_addr)
        ADDR_MODE: rd_data_ff <= mode_ff;
        ADDR_STATUS: rd_data_ff <= {5'h00, status_ff};
        ADDR_BAUD: rd_data_ff <= baud_ff;
        ADDR_TXS: rd_data_ff <= txs_ff;
        ADDR_RXB: rd_data_ff <= rxb_ff;
        default: rd_data_ff <= 8'h00;
      endcase
    end else begin
      rd_data_ff <= 8'h00;
    end
  end

  // Prescaler, stopped low while unpowered
  always_comb begin
    case (baud_ff[BAUD_TPS_HI:BAUD_TPS_LO])
      TPS_DIV2: pre_mask = PRE_MASK_DIV2;
      TPS_DIV8: pre_mask = PRE_MASK_DIV8;
      default: pre_mask = PRE_MASK_DIV32;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge unit_rst_b) begin
    if (!unit_rst_b) begin
      pre_ff <= 5'h00; // RULE22
    end else begin
      pre_ff <= pre_ff + 5'h01;
    end
  end

  // Base clock tick from the prescaler or the external timer
  always_comb begin
    if (!unit_power) begin
      base_tick = 1'b0;
    end else if (baud_ff[BAUD_TPS_HI:BAUD_TPS_LO] == TPS_TIMER) begin
      base_tick = i_timer_tick;
    end else begin
      base_tick = ((pre_ff & pre_mask) == pre_mask);
    end
  end

  // One bit lasts twice the divider period
  assign tx_limit = {baud_ff[BAUD_MDL_HI:BAUD_MDL_LO], 1'b0}; // RULE24
  assign rx_limit = (rx_state_ff == RX_START) ? {1'b0, baud_ff[BAUD_MDL_HI:BAUD_MDL_LO]} :
                    {baud_ff[BAUD_MDL_HI:BAUD_MDL_LO], 1'b0}; // RULE24

  // Transmit bit timer, restarted by the character write
  ast_baud_counter u_tx_timer (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_clear(!tx_en || tx_start),
    .i_tick(base_tick),
    .i_limit(tx_limit),
    .o_hit(tx_hit)
  );

  // Transmit sequencer
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tx_state_ff <= TX_IDLE;
      tx_sh_ff <= 8'h00;
      tx_bit_ff <= 3'h0;
      tx_out_ff <= 1'b1;
      tx_done_ff <= 1'b0;
    end else if (!tx_en) begin
      tx_state_ff <= TX_IDLE;
      tx_bit_ff <= 3'h0;
      tx_out_ff <= 1'b1;
      tx_done_ff <= 1'b0;
    end else begin
      tx_done_ff <= 1'b0;
      case (tx_state_ff)
        TX_IDLE: begin
          tx_out_ff <= 1'b1; // RULE10
          if (tx_start) begin
            tx_state_ff <= TX_START; // RULE7
            tx_sh_ff <= i_wr_data;
            tx_bit_ff <= 3'h0;
            tx_out_ff <= 1'b0; // RULE8
          end
        end
        TX_START: begin
          if (tx_hit) begin
            tx_state_ff <= TX_DATA;
            tx_out_ff <= tx_sh_ff[0]; // RULE8
          end
        end
        TX_DATA: begin
          if (tx_hit) begin
            tx_bit_ff <= tx_bit_ff + 3'h1;
            if (tx_bit_ff != last_bit) begin
              tx_out_ff <= tx_sh_ff[tx_bit_ff + 3'h1]; // RULE2
            end else if (parity_mode == PAR_NONE) begin
              tx_state_ff <= TX_STOP1; // RULE6
              tx_out_ff <= 1'b1;
            end else begin
              tx_state_ff <= TX_PAR;
              case (parity_mode)
                PAR_EVEN: tx_out_ff <= ^(tx_sh_ff & {mode_ff[MODE_CL], 7'h7f}); // RULE3 RULE25
                PAR_ODD: tx_out_ff <= ~^(tx_sh_ff & {mode_ff[MODE_CL], 7'h7f}); // RULE4 RULE25
                default: tx_out_ff <= 1'b0; // RULE5
              endcase
            end
          end
        end
        TX_PAR: begin
          if (tx_hit) begin
            tx_state_ff <= TX_STOP1;
            tx_out_ff <= 1'b1;
          end
        end
        TX_STOP1: begin
          if (tx_hit) begin
            if (mode_ff[MODE_SL]) begin
              tx_state_ff <= TX_STOP2;
            end else begin
              tx_state_ff <= TX_IDLE;
              tx_done_ff <= 1'b1; // RULE9
            end
          end
        end
        TX_STOP2: begin
          if (tx_hit) begin
            tx_state_ff <= TX_IDLE;
            tx_done_ff <= 1'b1; // RULE9
          end
        end
        default: begin
          tx_state_ff <= TX_IDLE;
        end
      endcase
    end
  end

  // Filtered serial input
  ast_noise_filter u_rx_filter (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_tick(base_tick),
    .i_force_high(!unit_power),
    .i_serial(i_serial_rx_pin),
    .o_level(rx_level)
  );

  // Falling edge of the filtered line
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rx_prev_ff <= 1'b1;
    end else begin
      rx_prev_ff <= rx_level;
    end
  end

  assign rx_fall = rx_en && rx_prev_ff && !rx_level;

  // Receive timer held clear between frames
  assign rx_clear = !rx_en || (rx_state_ff == RX_IDLE);

  ast_baud_counter u_rx_timer (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_clear(rx_clear),
    .i_tick(base_tick),
    .i_limit(rx_limit),
    .o_hit(rx_hit)
  );

  // Receive sequencer
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rx_state_ff <= RX_IDLE;
      rxs_ff <= 8'h00;
      rx_bit_ff <= 3'h0;
      rx_par_ff <= 1'b0;
    end else if (!rx_en) begin
      rx_state_ff <= RX_IDLE;
      rx_bit_ff <= 3'h0;
    end else begin
      case (rx_state_ff)
        RX_IDLE: begin
          if (rx_fall) begin
            rx_state_ff <= RX_START; // RULE13
          end
        end
        RX_START: begin
          if (rx_hit) begin
            if (!rx_level) begin
              rx_state_ff <= RX_DATA; // RULE13
              rxs_ff <= 8'h00;
              rx_bit_ff <= 3'h0;
              rx_par_ff <= 1'b0;
            end else begin
              rx_state_ff <= RX_IDLE;
            end
          end
        end
        RX_DATA: begin
          if (rx_hit) begin
            rxs_ff[rx_bit_ff] <= rx_level; // RULE14 RULE25
            rx_par_ff <= rx_par_ff ^ rx_level;
            rx_bit_ff <= rx_bit_ff + 3'h1;
            if (rx_bit_ff == last_bit) begin
              rx_state_ff <= (parity_mode == PAR_NONE) ? RX_STOP : RX_PAR; // RULE6
            end
          end
        end
        RX_PAR: begin
          if (rx_hit) begin
            rx_par_ff <= rx_par_ff ^ rx_level;
            rx_state_ff <= RX_STOP; // RULE15
          end
        end
        RX_STOP: begin
          if (rx_hit) begin
            rx_state_ff <= RX_IDLE; // RULE16
          end
        end
        default: begin
          rx_state_ff <= RX_IDLE;
        end
      endcase
    end
  end

  // Frame completion and its error causes
  assign frame_end = rx_en && (rx_state_ff == RX_STOP) && rx_hit;
  assign set_fe = frame_end && !rx_level; // RULE19
  assign set_ove = frame_end && (rxb_full_ff && !rd_rxb); // RULE20
  always_comb begin
    case (parity_mode)
      PAR_EVEN: set_pe = frame_end && rx_par_ff; // RULE3
      PAR_ODD: set_pe = frame_end && !rx_par_ff; // RULE4
      default: set_pe = 1'b0; // RULE5 RULE6
    endcase
  end

  // Receive-done pulse on every completed frame, error or not
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rx_done_ff <= 1'b0;
    end else begin
      rx_done_ff <= frame_end; // RULE14 RULE15 RULE17
    end
  end

  // Receive buffer, skipped on overrun
  always_ff @(posedge i_core_clk or negedge unit_rst_b) begin
    if (!unit_rst_b) begin
      rxb_ff <= RXB_RST; // RULE22
      rxb_full_ff <= 1'b0;
    end else begin
      if (frame_end && !set_ove) begin
        rxb_ff <= rxs_ff; // RULE14
      end
      // A new character beats a buffer read in the same cycle
      if (frame_end && !set_ove) begin
        rxb_full_ff <= 1'b1;
      end else if (rd_rxb) begin
        rxb_full_ff <= 1'b0; // RULE21
      end
    end
  end

  // Error status, cleared by a read; new errors win over the clear
  always_comb begin
    nxt_status = rd_status ? STAT_RST : status_ff; // RULE18
    if (set_pe) begin
      nxt_status[STAT_PE] = 1'b1;
    end
    if (set_fe) begin
      nxt_status[STAT_FE] = 1'b1;
    end
    if (set_ove) begin
      nxt_status[STAT_OVE] = 1'b1;
    end
  end

  always_ff @(posedge i_core_clk or negedge unit_rst_b) begin
    if (!unit_rst_b) begin
      status_ff <= STAT_RST; // RULE22
    end else begin
      status_ff <= nxt_status;
    end
  end
endmodule

// [ast_monitor.sv]
// Port-level assertions for the serial transceiver
`timescale 1ns/1ps
module ast_monitor (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // Register port
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [7:0] o_rd_data,
  // Line and events
  input wire logic o_serial_tx_pin,
  input wire logic o_serial_tx_pin_oe,
  input wire logic o_serial_rx_pin_sel,
  input wire logic o_tx_done_interrupt,
  input wire logic o_rx_done_interrupt
);
  import ast_pkg::*;
  logic [7:0] mode_ff;
  logic busy_ff;
  logic take;
  logic tx_on;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  // Transmitter powered and transmit enabled
  assign tx_on = mode_ff[MODE_POWER] && mode_ff[MODE_TXE];
  // Sequencer is idle again in the cycle of the done pulse
  assign take = i_wr_en && i_addr == ADDR_TXS && tx_on && (!busy_ff || o_tx_done_interrupt);
  // Mode shadow
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mode_ff <= MODE_RST;
    end else if (i_wr_en && i_addr == ADDR_MODE) begin
      mode_ff <= i_wr_data;
    end
  end
  // Frame in flight
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      busy_ff <= 1'b0;
    end else if (take) begin
      busy_ff <= 1'b1;
    end else if (o_tx_done_interrupt || !tx_on) begin
      busy_ff <= 1'b0;
    end
  end
  a_tx_pin_owner: assert property (o_serial_tx_pin_oe == tx_on) else $error("tx pin owner");
  a_rx_pin_claim: assert property (o_serial_rx_pin_sel == (mode_ff[7] && mode_ff[5])) else $error("rx sel");
  a_read_idle_zero: assert property (!$past(i_rd_en) |-> o_rd_data == 8'h00) else $error("rd data idle");
  a_mode_read_back: assert property ($past(i_rd_en) && $past(i_addr) == ADDR_MODE
    |-> o_rd_data == {mode_ff[7:1], 1'b1}) else $error("mode read");
  a_start_on_write: assert property (take |=> !o_serial_tx_pin [*4]) else $error("no start bit");
  a_done_after_frame: assert property (o_tx_done_interrupt |-> busy_ff ##1 !o_tx_done_interrupt)
    else $error("tx done");
  a_idle_line_high: assert property (!busy_ff && tx_on |-> o_serial_tx_pin) else $error("tx not idle");
  a_rx_done_claimed: assert property (o_rx_done_interrupt |-> o_serial_rx_pin_sel ##1 !o_rx_done_interrupt)
    else $error("rx done");
  // Main scenarios
  cover property (take);
  cover property (o_rx_done_interrupt);
  cover property ($past(i_rd_en) && $past(i_addr) == ADDR_STATUS && o_rd_data != 8'h00);
endmodule

bind ast_top ast_monitor i_mon (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_addr(i_addr),
  .i_wr_data(i_wr_data), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rd_data(o_rd_data),
  .o_serial_tx_pin(o_serial_tx_pin), .o_serial_tx_pin_oe(o_serial_tx_pin_oe),
  .o_serial_rx_pin_sel(o_serial_rx_pin_sel), .o_tx_done_interrupt(o_tx_done_interrupt),
  .o_rx_done_interrupt(o_rx_done_interrupt));

// [ast_line_peer.sv]
// Remote transceiver model on the serial line
`timescale 1ns/1ps
module ast_line_peer #(
  parameter int BIT_CLK = 32
) (
  // Clock
  input wire logic i_core_clk,
  // Line
  input wire logic i_serial_tx_pin,
  output logic o_line
);
  import ast_pkg::*;
  initial o_line = 1'b1;
  // Frame image, start first, idle ones after the stop
  function automatic logic [11:0] frame_bits(input logic [7:0] d, input logic cl, input logic [1:0] ps);
    logic [11:0] f;
    logic [7:0] m;
    int n;
    f = 12'hfff;
    m = cl ? d : {1'b0, d[6:0]};
    n = cl ? 8 : 7;
    f[0] = 1'b0;
    for (int i = 0; i < n; i++) begin
      f[1 + i] = m[i];
    end
    case (ps)
      PAR_EVEN: f[1 + n] = ^m;
      PAR_ODD: f[1 + n] = ~^m;
      PAR_ZERO: f[1 + n] = 1'b0;
      default: f[1 + n] = 1'b1;
    endcase
    return f;
  endfunction
  // Send one frame, each level held a whole bit
  task automatic drive_frame(input logic [11:0] f);
    for (int i = 0; i < 12; i++) begin
      @(posedge i_core_clk);
      o_line <= f[i];
      repeat (BIT_CLK - 1) @(posedge i_core_clk);
    end
  endtask
  // Catch one frame, sampling mid-bit
  task automatic catch_frame(output logic [11:0] f);
    int w;
    w = 0;
    while (i_serial_tx_pin !== 1'b0 && w < 400) begin
      @(posedge i_core_clk);
      w++;
    end
    repeat (BIT_CLK / 2) @(posedge i_core_clk);
    for (int i = 0; i < 12; i++) begin
      f[i] = i_serial_tx_pin;
      repeat (BIT_CLK) @(posedge i_core_clk);
    end
  endtask
endmodule

// [testbench.sv]
// Self-checking bench for the serial transceiver
`timescale 1ns/1ps
module testbench;
  import ast_pkg::*;
  localparam int BIT_CLK = 32;
  logic i_core_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic [2:0] i_addr = 3'h0;
  logic [7:0] i_wr_data = 8'h00;
  logic i_wr_en = 1'b0;
  logic i_rd_en = 1'b0;
  logic [7:0] o_rd_data;
  logic tx, oe, sel, tx_done, rx_done, line;
  logic [7:0] exp_q[$];
  logic rd_seen = 1'b0;
  logic tmr = 1'b0;
  logic [15:0] seed = 16'h1d5a;
  int n_fail = 0;
  int tests_run = 0;
  int tx_cnt = 0;
  int rx_cnt = 0;
  int cyc = 0;
  int done_at = 1;
  int wr_at = 0;
  // Clock
  always #50 i_core_clk = ~i_core_clk;
  ast_top i_dut (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wr_data(i_wr_data),
    .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rd_data(o_rd_data), .i_timer_tick(tmr),
    .o_serial_tx_pin(tx), .o_serial_tx_pin_oe(oe), .i_serial_rx_pin(line), .o_serial_rx_pin_sel(sel),
    .o_tx_done_interrupt(tx_done), .o_rx_done_interrupt(rx_done));
  ast_line_peer #(.BIT_CLK(BIT_CLK)) i_peer (.i_core_clk(i_core_clk), .i_serial_tx_pin(tx), .o_line(line));
  task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Event counters and read-data watcher
  always @(posedge i_core_clk) begin
    cyc++;
    if (i_wr_en && i_addr == ADDR_TXS && wr_at < done_at) wr_at = cyc;
    if (tx_done === 1'b1) done_at = cyc;
    if (tx_done === 1'b1) tx_cnt++;
    if (rx_done === 1'b1) rx_cnt++;
    if (rd_seen) check("rd_data", {4'h0, o_rd_data}, {4'h0, exp_q.pop_front()});
    rd_seen <= i_rd_en;
    tmr <= ~tmr; // Timer base tick every second cycle
  end
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    i_addr <= a;
    i_wr_data <= d;
    i_wr_en <= 1'b1;
    @(posedge i_core_clk);
    i_wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge i_core_clk);
    i_addr <= a;
    i_rd_en <= 1'b1;
    exp_q.push_back(e);
    @(posedge i_core_clk);
    i_rd_en <= 1'b0;
  endtask
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    #(100 * 40000);
    n_fail++;
    wrap_up;
  end
  // Main sequence
  initial begin
    logic [11:0] f;
    logic [11:0] got;
    logic [7:0] d;
    logic [1:0] ps;
    logic cl;
    logic [2:0] st;
    int nb;
    int n0;
    repeat (3) @(posedge i_core_clk);
    i_rst_b <= 1'b1;
    rd(ADDR_MODE, MODE_RST);
    rd(ADDR_STATUS, 8'h00);
    rd(ADDR_BAUD, BAUD_RST);
    rd(ADDR_TXS, TXS_RST);
    rd(ADDR_RXB, RXB_RST);
    rd(3'h7, 8'h00);
    wr(ADDR_BAUD, {TPS_DIV2, 6'h08});
    wr(ADDR_MODE, 8'h80);
    // Transmit in every parity mode, busy write refused
    for (int i = 0; i < 5; i++) begin
      ps = i[1:0];
      cl = i != 2 && i != 4;
      seed = lfsr(seed);
      d = seed[7:0];
      nb = (cl ? 10 : 9) + (ps != PAR_NONE) + i[0];
      if (i == 4) wr(ADDR_BAUD, {TPS_TIMER, 6'h08});
      wr(ADDR_MODE, {3'b110, ps, cl, i[0], 1'b1});
      n0 = tx_cnt;
      fork
        i_peer.catch_frame(got);
        begin
          wr(ADDR_TXS, d);
          wr(ADDR_TXS, ~d);
        end
      join
      check("tx_frame", got, i_peer.frame_bits(d, cl, ps));
      check("tx_done_count", 12'(tx_cnt - n0), 12'h001);
      check("tx_done_time", 12'((done_at - wr_at) inside {[nb * 32 : nb * 32 + 3]}), 12'h001);
      rd(ADDR_TXS, d);
    end
    n0 = rx_cnt;
    i_peer.drive_frame(i_peer.frame_bits(8'h5a, 1'b1, PAR_NONE));
    check("rx_off_count", 12'(rx_cnt - n0), 12'h000);
    // Receive clean and faulty frames
    for (int i = 0; i < 8; i++) begin
      ps = i[1:0];
      cl = !i[0] || i[1];
      seed = lfsr(seed);
      d = seed[7:0];
      nb = cl ? 8 : 7;
      f = i_peer.frame_bits(d, cl, ps);
      st = (i > 3) ? ((ps == PAR_NONE) ? 3'h2 : {ps[1], 2'b00}) : 3'h0;
      if (i > 3) f[1 + nb] = (ps == PAR_NONE) ? 1'b0 : !f[1 + nb];
      wr(ADDR_MODE, {3'b111, ps, cl, 1'b1, 1'b1});
      n0 = rx_cnt;
      i_peer.drive_frame(f);
      check("rx_done_count", 12'(rx_cnt - n0), 12'h001);
      rd(ADDR_STATUS, {5'h00, st});
      rd(ADDR_RXB, cl ? d : {1'b0, d[6:0]});
    end
    // Overrun, then clear-on-read
    n0 = rx_cnt;
    i_peer.drive_frame(i_peer.frame_bits(d, 1'b1, PAR_EVEN));
    i_peer.drive_frame(i_peer.frame_bits(~d, 1'b1, PAR_EVEN));
    check("rx_done_count", 12'(rx_cnt - n0), 12'h002);
    rd(ADDR_STATUS, 8'h01);
    rd(ADDR_RXB, d);
    rd(ADDR_STATUS, 8'h00);
    // Power off resets status and buffers
    i_peer.drive_frame(i_peer.frame_bits(d, 1'b1, PAR_ODD));
    wr(ADDR_MODE, 8'h80);
    wr(ADDR_MODE, 8'h00);
    #1;
    check("pins_released", {10'h000, oe, sel}, 12'h000);
    rd(ADDR_STATUS, 8'h00);
    rd(ADDR_RXB, RXB_RST);
    rd(ADDR_TXS, TXS_RST);
    repeat (3) @(posedge i_core_clk);
    wrap_up;
  end
endmodule
